// File: verilog/loop_cal_pkg.sv
// Purpose: Shared constants and carrier types for the loop compensation
//          calibration controller.
// Assumes: 16-bit command registers; resonance ratio as Fsw/Flc in 8.8 form.
// Notes:   Command codes below select registers on the command port.
package loop_cal_pkg;

	// Command codes of the register port.
	localparam logic [7:0] CMD_CAL_MODE = 8'hD0;
	localparam logic [7:0] CMD_COMP_MODEL = 8'hD1;
	localparam logic [7:0] CMD_FB_GAIN = 8'hD2;
	localparam logic [7:0] CMD_DAMPING = 8'hD3;
	localparam logic [7:0] CMD_LOOP_CFG = 8'hD4;

	// Reset values.
	localparam logic [15:0] CAL_MODE_RST = 16'h024B;
	localparam logic [15:0] FB_GAIN_RST = 16'h0080;
	localparam logic [15:0] DAMPING_RST = 16'h0180;
	localparam logic [15:0] LOOP_CFG_RST = 16'h0000;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;

	// Field positions in the calibration mode and loop configuration registers.
	localparam int MODE_AUTO_STORE_BIT = 2;
	localparam int MODE_CONT_BIT = 8;
	localparam int MODE_AFTER_RAMP_BIT = 9;
	localparam int MODE_FIRST_ONLY_BIT = 12;
	localparam int LOOP_NEG_DUTY_BIT = 0;

	// Clamp limits of Fsw/Flc, integer part in the high byte.
	localparam logic [15:0] RATIO_MIN = 16'h1900;
	localparam logic [15:0] RATIO_MAX = 16'h4200;

	// Periodic calibration interval.
	localparam int CLK_HZ = 50_000_000;
	localparam int CAL_PERIOD_MS = 800;
	localparam longint CAL_PERIOD_CYC_L =
		longint'(CLK_HZ) * CAL_PERIOD_MS / 1000;
	localparam logic [31:0] CAL_PERIOD_CYC = CAL_PERIOD_CYC_L[31:0];

	// Settings handed to the compensation datapath.
	typedef struct packed {
		logic [15:0] ratio_flc;
		logic [15:0] fb_gain;
		logic [15:0] damping_ratio;
		logic neg_duty_en;
	} loop_settings_t;

	// Inputs for closed-loop pole placement.
	typedef struct packed {
		logic [7:0] fsw_code;
		logic [15:0] ratio_flc;
		logic [7:0] vout_code;
	} pole_select_t;

endpackage

// File: verilog/loop_cal_ctrl.sv
// Purpose: Selects, sequences, measures and stores the output filter
//          resonance ratio used by the state-space compensation loop.
// Assumes: rst marks input power; pins are asynchronous; NVM shares clk.
// Notes:   Model writes are refused while the output is enabled.
`timescale 1ns/1ns
`default_nettype none
module loop_cal_ctrl
	import loop_cal_pkg::*;
#(
	parameter logic [31:0] CAL_PERIOD = CAL_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata,
	output logic cmd_write_refused,
	input wire logic output_enable_pin,
	input wire logic ramp_done_pin,
	input wire logic vout_above_90_pin,
	input wire logic [15:0] nvm_ratio_flc,
	output logic nvm_store_all,
	output logic meas_start,
	input wire logic meas_done,
	input wire logic [15:0] meas_ratio_flc,
	input wire logic [7:0] fsw_code,
	input wire logic [7:0] vout_code,
	output loop_settings_t loop_settings,
	output pole_select_t pole_select,
	output logic cal_active,
	output logic power_good_out,
	output logic power_good_oe
);

	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_RAMP = 4'b0010,
		ST_MEAS = 4'b0100,
		ST_RUN = 4'b1000
	} cal_state_t;

	// Saturates a measured ratio into the legal window.
	function automatic logic [15:0] clamp_ratio(input logic [15:0] r);
		if (r < RATIO_MIN) begin
			clamp_ratio = RATIO_MIN;
		end else if (r > RATIO_MAX) begin
			clamp_ratio = RATIO_MAX;
		end else begin
			clamp_ratio = r;
		end
	endfunction

	// Decides whether the end of a ramp must start a calibration.
	function automatic logic cal_after_ramp(input logic [15:0] mode,
		input logic first_done);
		cal_after_ramp = mode[MODE_CONT_BIT] |
			(mode[MODE_AFTER_RAMP_BIT] &
			~(mode[MODE_FIRST_ONLY_BIT] & first_done));
	endfunction

	cal_state_t state_q;
	cal_state_t state_d;
	logic [2:0] sync1_q, sync2_q, sync3_q, filt_q;
	logic enable_s, ramp_done_s, above_90_s;
	logic [15:0] cal_mode_q, comp_model_q, fb_gain_q, damping_q, loop_cfg_q;
	logic [15:0] rdata_q;
	logic refused_q, first_done_q, cal_ok_q, store_armed_q, store_q, start_q;
	logic pg_q;
	logic [31:0] period_cnt_q;
	logic period_hit, cal_finish, wr_mode, wr_model, model_locked;
	loop_settings_t settings_q;
	pole_select_t pole_q;

	// Pin inputs pass three flops; a change counts when the last two agree.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
					filt_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= (gi == 0) ? output_enable_pin :
						(gi == 1) ? ramp_done_pin : vout_above_90_pin;
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
					if (sync2_q[gi] == sync3_q[gi]) begin
						filt_q[gi] <= sync3_q[gi];
					end
				end
			end
		end
	endgenerate
	// Filtered pin levels under the names that the sequencer and power good logic use.
	assign enable_s = filt_q[0];
	assign ramp_done_s = filt_q[1];
	assign above_90_s = filt_q[2];

	// Command decode; model writes are refused while the output is enabled.
	assign model_locked = state_q != ST_OFF;
	assign wr_mode = cmd_wr && (cmd_code == CMD_CAL_MODE);
	assign wr_model = cmd_wr && (cmd_code == CMD_COMP_MODEL) &&
		!model_locked;
	assign cal_finish = (state_q == ST_MEAS) && meas_done && enable_s;
	assign period_hit = period_cnt_q >= CAL_PERIOD - 32'h0000_0001;

	// Calibration sequencer.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (enable_s) begin
					state_d = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (!enable_s) begin
					state_d = ST_OFF;
				end else if (ramp_done_s) begin
					// Disabled or already-done modes skip straight to run.
					if (cal_after_ramp(cal_mode_q, first_done_q)) begin
						state_d = ST_MEAS;
					end else begin
						state_d = ST_RUN;
					end
				end
			end
			ST_MEAS: begin
				if (!enable_s) begin
					state_d = ST_OFF;
				end else if (meas_done) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!enable_s) begin
					state_d = ST_OFF;
				end else if (cal_mode_q[MODE_CONT_BIT] && period_hit) begin
					state_d = ST_MEAS;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// Measurement start is one pulse on entry to the measuring state.
	always_ff @(posedge clk) begin
		if (rst) begin
			start_q <= 1'b0;
		end else begin
			start_q <= (state_d == ST_MEAS) && (state_q != ST_MEAS);
		end
	end

	// Interval timer runs only while continuous mode is live in run state.
	always_ff @(posedge clk) begin
		if (rst) begin
			period_cnt_q <= 32'h0000_0000;
		end else if (state_q != ST_RUN || !cal_mode_q[MODE_CONT_BIT] ||
			period_hit) begin
			period_cnt_q <= 32'h0000_0000;
		end else begin
			period_cnt_q <= period_cnt_q + 32'h0000_0001;
		end
	end

	// Mode register keeps every written bit; only a few are decoded.
	always_ff @(posedge clk) begin
		if (rst) begin
			cal_mode_q <= CAL_MODE_RST;
		end else if (wr_mode) begin
			cal_mode_q <= cmd_wdata;
		end
	end

	// Resonance field: host write, measurement result, or NVM restore.
	always_ff @(posedge clk) begin
		if (rst) begin
			comp_model_q <= 16'h0000;
		end else if (state_q != ST_OFF && state_d == ST_OFF) begin
			comp_model_q <= nvm_ratio_flc;
		end else if (cal_finish) begin
			comp_model_q <= clamp_ratio(meas_ratio_flc);
		end else if (wr_model) begin
			comp_model_q <= cmd_wdata;
		end else if (rst == 1'b0 && state_q == ST_OFF && !first_done_q &&
			!cal_ok_q && comp_model_q == 16'h0000) begin
			// Load the stored value once after power-up.
			comp_model_q <= nvm_ratio_flc;
		end
	end

	// Tuning registers steer the loop directly.
	always_ff @(posedge clk) begin
		if (rst) begin
			fb_gain_q <= FB_GAIN_RST;
			damping_q <= DAMPING_RST;
			loop_cfg_q <= LOOP_CFG_RST;
		end else if (cmd_wr) begin
			case (cmd_code)
				CMD_FB_GAIN: fb_gain_q <= cmd_wdata;
				CMD_DAMPING: damping_q <= cmd_wdata;
				CMD_LOOP_CFG: loop_cfg_q <= cmd_wdata;
				default: ;
			endcase
		end
	end

	// First calibration since power-up is remembered until reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			first_done_q <= 1'b0;
		end else if (cal_finish) begin
			first_done_q <= 1'b1;
		end
	end

	// Calibration status for power good, cleared by each new ramp.
	always_ff @(posedge clk) begin
		if (rst) begin
			cal_ok_q <= 1'b0;
		end else if (state_q == ST_OFF) begin
			cal_ok_q <= 1'b0;
		end else if (cal_finish) begin
			cal_ok_q <= 1'b1;
		end else if (state_q == ST_RAMP && state_d == ST_RUN) begin
			// No calibration planned for this ramp counts as done.
			cal_ok_q <= 1'b1;
		end
	end

	// Auto-store arms on a write with bit 2 set; arming wins over the clear on completion.
	always_ff @(posedge clk) begin
		if (rst) begin
			store_armed_q <= 1'b0;
			store_q <= 1'b0;
		end else begin
			store_q <= cal_finish && store_armed_q;
			if (wr_mode && cmd_wdata[MODE_AUTO_STORE_BIT]) begin
				store_armed_q <= 1'b1;
			end else if (cal_finish) begin
				store_armed_q <= 1'b0;
			end
		end
	end

	// Settings for the compensation datapath, refreshed every cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			settings_q <= '0;
			pole_q <= '0;
		end else begin
			settings_q.ratio_flc <= comp_model_q;
			settings_q.fb_gain <= fb_gain_q;
			settings_q.damping_ratio <= damping_q;
			settings_q.neg_duty_en <= loop_cfg_q[LOOP_NEG_DUTY_BIT];
			pole_q.fsw_code <= fsw_code;
			pole_q.ratio_flc <= comp_model_q;
			pole_q.vout_code <= vout_code;
		end
	end

	// Register readback, one cycle after the read strobe.
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= UNMAPPED_READ;
			refused_q <= 1'b0;
		end else begin
			refused_q <= cmd_wr && (cmd_code == CMD_COMP_MODEL) &&
				model_locked;
			if (cmd_rd) begin
				case (cmd_code)
					CMD_CAL_MODE: rdata_q <= cal_mode_q;
					CMD_COMP_MODEL: rdata_q <= comp_model_q;
					CMD_FB_GAIN: rdata_q <= fb_gain_q;
					CMD_DAMPING: rdata_q <= damping_q;
					CMD_LOOP_CFG: rdata_q <= loop_cfg_q;
					default: rdata_q <= UNMAPPED_READ;
				endcase
			end
		end
	end
	// Power good is open drain: it pulls low until ready.
	always_ff @(posedge clk) begin
		if (rst) begin
			pg_q <= 1'b0;
		end else begin
			pg_q <= enable_s && above_90_s && cal_ok_q;
		end
	end
	// Outputs come from their registers or the state flop; power good data is tied low.
	assign cmd_rdata = rdata_q;
	assign cmd_write_refused = refused_q;
	assign nvm_store_all = store_q;
	assign meas_start = start_q;
	assign loop_settings = settings_q;
	assign pole_select = pole_q;
	assign cal_active = state_q == ST_MEAS;
	assign power_good_out = 1'b0;
	assign power_good_oe = !pg_q;

endmodule
`default_nettype wire

// File: tb/loop_cal_meas_model.sv
// Purpose: Measurement engine and user NVM stand-in for the controller.
// Assumes: One measurement at a time, answered after a short or long delay.
// Notes: The result bus toggles outside the answer cycle.
`timescale 1ns/1ns
`default_nettype none
module loop_cal_meas_model (
	input wire logic clk,
	input wire logic meas_start,
	input wire logic slow,
	input wire logic [15:0] ratio,
	output logic meas_done = 1'b0,
	output logic [15:0] meas_ratio_flc = 16'h5A5A,
	input wire logic nvm_store_all,
	input wire logic [15:0] store_val,
	output logic [15:0] nvm_ratio_flc = 16'h2400
);
	logic [3:0] cnt_q = 4'h0;
	logic store_seen_q = 1'b0;
	// NVM takes the ratio a cycle after the store pulse, because the
	// settings bus only shows the stored value one cycle later.
	always_ff @(posedge clk) begin
		store_seen_q <= nvm_store_all;
		if (store_seen_q) begin
			nvm_ratio_flc <= store_val;
		end
	end
	// Answer a start after a delay; stale data would hide a sampling slip.
	always_ff @(posedge clk) begin
		meas_done <= cnt_q == 4'h1;
		meas_ratio_flc <= (cnt_q == 4'h1) ? ratio : ~meas_ratio_flc;
		if (meas_start)
			cnt_q <= slow ? 4'h9 : 4'h2;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
endmodule
`default_nettype wire

// File: tb/loop_cal_ctrl_assertions.sv
// Purpose: Port-level assertions for the calibration controller.
// Assumes: Pin inputs stay steady for several cycles around each change.
// Notes: Attached to every controller instance by the bind at the foot.
`timescale 1ns/1ns
`default_nettype none
module loop_cal_ctrl_assertions
	import loop_cal_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_write_refused,
	input wire logic vout_above_90_pin,
	input wire logic nvm_store_all,
	input wire logic meas_start,
	input wire logic meas_done,
	input wire logic [15:0] meas_ratio_flc,
	input wire logic [7:0] fsw_code,
	input wire logic [7:0] vout_code,
	input wire loop_settings_t loop_settings,
	input wire pole_select_t pole_select,
	input wire logic cal_active,
	input wire logic power_good_out,
	input wire logic power_good_oe
);
	logic [15:0] exp_q;
	// Clamped copy of each result, so the stored ratio can be compared.
	always_ff @(posedge clk) begin
		if (meas_done)
			exp_q <= (meas_ratio_flc < RATIO_MIN) ? RATIO_MIN :
				(meas_ratio_flc > RATIO_MAX) ? RATIO_MAX : meas_ratio_flc;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	start_pulse_a: assert property (meas_start |->
		cal_active ##1 !meas_start)
		else $error("bad start pulse");
	clamp_store_a: assert property (meas_done && cal_active |->
		##[1:2] loop_settings.ratio_flc == exp_q)
		else $error("ratio not stored clamped");
	store_cause_a: assert property (nvm_store_all |->
		$past(meas_done) || $past(meas_done, 2))
		else $error("store without calibration");
	store_once_a: assert property (nvm_store_all |=> !nvm_store_all [*8])
		else $error("store repeated");
	refuse_cause_a: assert property (cmd_write_refused |->
		$past(cmd_wr) && $past(cmd_code) == CMD_COMP_MODEL)
		else $error("refusal without model write");
	host_set_a: assert property ($changed({loop_settings.fb_gain,
		loop_settings.damping_ratio, loop_settings.neg_duty_en}) |->
		$past(cmd_wr) || $past(cmd_wr, 2) || $past(rst, 2))
		else $error("setting changed without write");
	pole_follow_a: assert property (!$past(rst) |->
		pole_select.fsw_code == $past(fsw_code) &&
		pole_select.vout_code == $past(vout_code))
		else $error("pole inputs not followed");
	pg_release_a: assert property ($fell(power_good_oe) |->
		$past(vout_above_90_pin, 3))
		else $error("power good before output up");
	pg_data_a: assert property (power_good_out == 1'b0)
		else $error("power good data not low");
	cover property (meas_start);
	cover property (nvm_store_all);
	cover property (cmd_write_refused);
	cover property ($fell(power_good_oe));
endmodule
bind loop_cal_ctrl loop_cal_ctrl_assertions loop_cal_ctrl_assertions_i (.*);
`default_nettype wire

// File: tb/loop_cal_ctrl_tb.sv
// Purpose: Self-checking bench for the calibration controller.
// Assumes: Calibration period shortened to 50 cycles.
// Notes: Pins pass a filter, so each step waits several cycles.
`timescale 1ns/1ns
`default_nettype none
module loop_cal_ctrl_tb
	import loop_cal_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0;
	logic en = 1'b0, ramp = 1'b0, up = 1'b0, slow = 1'b0, refused;
	logic cmd_write_refused, nvm_store_all, meas_start, meas_done;
	logic cal_active, power_good_out, power_good_oe;
	logic [7:0] cmd_code = 8'h00;
	logic [7:0] fsw = 8'h3C, vout = 8'h2A;
	logic [15:0] cmd_wdata = 16'h0000, ratio = 16'h0000;
	logic [15:0] cmd_rdata, meas_ratio_flc, rd, nvm_ratio_flc;
	loop_settings_t loop_settings;
	pole_select_t pole_select;
	int num_errors = 0, cmp_count = 0, n_cal, n_st;
	logic [7:0] codes [5] = '{CMD_CAL_MODE, CMD_FB_GAIN, CMD_DAMPING,
		CMD_LOOP_CFG, 8'h00};
	logic [15:0] rst_v [5] = '{16'h024B, 16'h0080, 16'h0180, 16'h0000,
		16'h0000};
	loop_cal_ctrl #(.CAL_PERIOD(32'h0000_0032)) loop_cal_ctrl_i (
		.clk, .rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata,
		.cmd_write_refused, .output_enable_pin(en), .ramp_done_pin(ramp),
		.vout_above_90_pin(up), .nvm_ratio_flc, .nvm_store_all,
		.meas_start, .meas_done, .meas_ratio_flc, .fsw_code(fsw),
		.vout_code(vout), .loop_settings, .pole_select, .cal_active,
		.power_good_out, .power_good_oe
	);
	loop_cal_meas_model loop_cal_meas_model_i (
		.clk, .meas_start, .slow, .ratio, .meas_done, .meas_ratio_flc,
		.nvm_store_all, .store_val(loop_settings.ratio_flc), .nvm_ratio_flc
	);
	// Free-running clock.
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic final_report();
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// One strobe per call; the refused pulse is seen one cycle later.
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		cmd_wr = 1'b1;
		cmd_code = c;
		cmd_wdata = d;
		@(negedge clk);
		cmd_wr = 1'b0;
		refused = cmd_write_refused;
	endtask
	task automatic rdc(input logic [7:0] c);
		@(negedge clk);
		cmd_rd = 1'b1;
		cmd_code = c;
		@(negedge clk);
		cmd_rd = 1'b0;
		rd = cmd_rdata;
	endtask
	// Counts starts and stores, since a missed or extra one is the fault.
	task automatic watch(input int cyc);
		n_cal = 0;
		n_st = 0;
		repeat (cyc) begin
			@(negedge clk);
			n_cal += meas_start;
			n_st += nvm_store_all;
		end
		n_cal = (n_cal > 1) ? 2 : n_cal;
	endtask
	task automatic run(input logic [15:0] r, input int cyc);
		ratio = r;
		en = 1'b1;
		up = 1'b1;
		repeat (8) @(negedge clk);
		check(power_good_oe, 1'b1);
		ramp = 1'b1;
		watch(cyc);
	endtask
	task automatic off();
		en = 1'b0;
		up = 1'b0;
		ramp = 1'b0;
		repeat (8) @(negedge clk);
	endtask
	// A hang ends the run as a failure.
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		final_report();
	end
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		foreach (codes[i]) begin
			rdc(codes[i]);
			check(rd, rst_v[i]);
		end
		rdc(CMD_COMP_MODEL);
		check(rd, 16'h2400);
		check(loop_settings.neg_duty_en, 1'b0);
		wr(CMD_CAL_MODE, 16'h124B);
		run(16'h1000, 100);
		check(n_cal, 1);
		check(power_good_oe, 1'b0);
		rdc(CMD_COMP_MODEL);
		check(rd, 16'h1900);
		check(rd[15:8] >= 8'd25 && rd[15:8] <= 8'd66, 1'b1);
		wr(CMD_COMP_MODEL, 16'h2100);
		check(refused, 1'b1);
		off();
		rdc(CMD_COMP_MODEL);
		check(rd, 16'h2400);
		run(16'h1000, 100);
		check(n_cal, 0);
		off();
		wr(CMD_CAL_MODE, 16'h024B);
		slow = 1'b1;
		run(16'h5000, 100);
		check(n_cal, 1);
		check(n_st, 0);
		rdc(CMD_COMP_MODEL);
		check(rd, 16'h4200);
		off();
		wr(CMD_CAL_MODE, 16'h024F);
		run(16'h2A34, 100);
		check(n_st, 1);
		rdc(CMD_COMP_MODEL);
		check(rd, 16'h2A34);
		off();
		run(16'h2A34, 100);
		check(n_st, 0);
		off();
		wr(CMD_CAL_MODE, 16'h004B);
		wr(CMD_COMP_MODEL, 16'h2000);
		check(refused, 1'b0);
		run(16'h1000, 100);
		check(n_cal, 0);
		check(loop_settings.ratio_flc, 16'h2000);
		off();
		rdc(CMD_COMP_MODEL);
		check(rd, 16'h2A34);
		wr(CMD_CAL_MODE, 16'h034B);
		slow = 1'b0;
		run(16'h3000, 300);
		check(n_cal, 2);
		wr(CMD_CAL_MODE, 16'h024B);
		watch(200);
		check(n_cal, 0);
		wr(CMD_CAL_MODE, 16'h034B);
		watch(200);
		check(n_cal, 2);
		off();
		wr(CMD_FB_GAIN, 16'h00CC);
		wr(CMD_LOOP_CFG, 16'h0001);
		fsw = 8'h41;
		vout = 8'h17;
		@(negedge clk);
		check(loop_settings.fb_gain, 16'h00CC);
		check(loop_settings.neg_duty_en, 1'b1);
		check(loop_settings.damping_ratio, 16'h0180);
		check(pole_select.fsw_code, 8'h41);
		check(pole_select.vout_code, 8'h17);
		check(pole_select.ratio_flc, 16'h2A34);
		final_report();
	end
endmodule
`default_nettype wire
